// >>> dv/cmp_ref_ctrl_bench.sv
module cmp_ref_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0;
  logic cmp = 0, pin = 0, pre = 0, on = 0, gen = 0, ce_in = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic rdy, gq, ga, inc, pw, rl, cc, pc, c2, eg;
  logic [3:0] tap;
  int miscompares = 0, comparisons = 0, pulses = 0;
  ctr_far_side far (.run(run), .cmp_level(cmp), .pin_level(pin),
    .counter_clock(cc), .prescaler_clock(pc), .comparator2_out(c2),
    .external_gate_pin(eg));
  cmp_ref_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(ce_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(), .comparator2_out(c2), .counter_clock(cc),
    .prescaler_enable(pre), .prescaler_clock(pc), .external_gate_pin(eg),
    .counter_on(on), .gate_enable(gen), .counter_gate_q(gq),
    .counter_gate_active_q(ga), .counter_increment_q(inc),
    .reference_power_q(pw), .reference_range_low_q(rl),
    .reference_tap_q(tap));
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    if (inc === 1'b1)
      pulses++;
  end
  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  initial
  begin
    #200000;
    miscompares++;
    print_verdict;
  end
  initial
  begin
    wt(2);
    hresetn <= 1'b1;
    rdchk(32'h0, 32'h2);
    rdchk(32'h4, 32'h0);
    xfer(1'b1, 32'h0, 32'hff);
    rdchk(32'h0, 32'h3);
    xfer(1'b1, 32'h4, 32'hff);
    rdchk(32'h4, 32'haf);
    rdchk(32'h8, 32'h0);
    xfer(1'b1, 32'h4, 32'ha5);
    wt(3);
    chk({pw, rl, tap}, 32'h35);
    xfer(1'b1, 32'h4, 32'h8f);
    wt(3);
    chk({pw, rl, tap}, 32'h2f);
    xfer(1'b1, 32'h4, 32'h20);
    wt(3);
    chk({pw, rl, tap}, 32'h10);
    on <= 1'b1;
    xfer(1'b1, 32'h0, 32'h0);
    run = 1'b1;
    repeat (6) @(posedge cc);
    run = 1'b0;
    wt(30);
    chk(pulses, 6);
    pre <= 1'b1;
    pulses = 0;
    run = 1'b1;
    repeat (8) @(posedge cc);
    run = 1'b0;
    wt(30);
    chk(pulses, 4);
    pre <= 1'b0;
    gen <= 1'b1;
    pin <= 1'b1;
    xfer(1'b1, 32'h0, 32'h2);
    wt(6);
    chk({ga, gq}, 32'h3);
    pin <= 1'b0;
    gen <= 1'b0;
    xfer(1'b1, 32'h0, 32'h0);
    cmp <= 1'b1;
    wt(6);
    chk({ga, gq}, 32'h1);
    cmp <= 1'b0;
    xfer(1'b1, 32'h0, 32'h1);
    cmp <= 1'b1;
    wt(8);
    chk(gq, 32'h0);
    run = 1'b1;
    @(posedge cc);
    run = 1'b0;
    wt(30);
    chk(gq, 32'h1);
    ce_in <= 1'b0;
    xfer(1'b1, 32'h0, 32'h3);
    ce_in <= 1'b1;
    rdchk(32'h0, 32'h1);
    hresetn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    rdchk(32'h0, 32'h2);
    rdchk(32'h4, 32'h0);
    print_verdict;
  end
endmodule

// >>> dv/ctr_far_side.sv
module ctr_far_side (
  input wire logic run,
  input wire logic cmp_level,
  input wire logic pin_level,
  output logic counter_clock,
  output logic prescaler_clock,
  output logic comparator2_out,
  output logic external_gate_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // counter clock stands low between bursts; prescaler divides it by two
  initial
  begin
    counter_clock = 1'b0;
    prescaler_clock = 1'b0;
    forever
    begin
      wait (run);
      #50 counter_clock = 1'b1;
      prescaler_clock = ~prescaler_clock;
      #50 counter_clock = 1'b0;
    end
  end
  assign comparator2_out = cmp_level;
  assign external_gate_pin = pin_level;
endmodule

// >>> verilog/cmp_ref_ctrl.sv
`include "cmp_ref_map.svh"
module cmp_ref_ctrl
  import cmp_ref_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comparator2_out,
  input wire logic counter_clock,
  input wire logic prescaler_enable,
  input wire logic prescaler_clock,
  input wire logic external_gate_pin,
  input wire logic counter_on,
  input wire logic gate_enable,
  output logic counter_gate_q,
  output logic counter_gate_active_q,
  output logic counter_increment_q,
  output logic reference_power_q,
  output logic reference_range_low_q,
  output logic [3:0] reference_tap_q
);
  import cmp_ref_pkg::*;

  reg8_type gate_sync_q;
  reg8_type ref_level_q;
  logic wr_pend_q;
  logic [`ADDR_MSB:`ADDR_LSB] wr_addr_q;
  logic cmp_level;
  logic cmp_rise;
  logic cmp_fall;
  logic clk_level;
  logic clk_rise;
  logic clk_fall;
  logic psc_level;
  logic psc_rise;
  logic psc_fall;
  logic gate_level;
  logic gate_rise;
  logic gate_fall;
  logic latch_fall;
  logic latch_rise;
  logic cmp_latched_q;
  logic cmp_path;
  logic [7:0] rd_addr;
  logic addr_ok;
  logic bus_go;

  edge_sync cmp_sync_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(comparator2_out),
    .level_q(cmp_level), .rise_q(cmp_rise), .fall_q(cmp_fall));
  edge_sync clk_sync_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(counter_clock),
    .level_q(clk_level), .rise_q(clk_rise), .fall_q(clk_fall));
  edge_sync psc_sync_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .async_in(prescaler_clock),
    .level_q(psc_level), .rise_q(psc_rise), .fall_q(psc_fall));
  edge_sync gate_sync_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .async_in(external_gate_pin), .level_q(gate_level), .rise_q(gate_rise),
    .fall_q(gate_fall));

  assign bus_go = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign rd_addr = {haddr[`ADDR_MSB:`ADDR_LSB], 2'b00};
  assign latch_fall = prescaler_enable ? psc_fall : clk_fall;
  assign latch_rise = prescaler_enable ? psc_rise : clk_rise;
  assign cmp_path = gate_sync_q[`SYNC_BIT] ? cmp_latched_q : cmp_level;

  // write address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else if (ce)
    begin
      wr_pend_q <= bus_go & hwrite;
      wr_addr_q <= haddr[`ADDR_MSB:`ADDR_LSB];
    end
  end

  // control registers, reserved bits masked off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_sync_q <= `GATE_SYNC_RESET;
      ref_level_q <= `REF_LEVEL_RESET;
    end
    else if (ce && wr_pend_q)
    begin
      if ({wr_addr_q, 2'b00} == `GATE_SYNC_CTRL_ADDR)
        gate_sync_q <= hwdata[7:0] & `GATE_SYNC_MASK;
      if ({wr_addr_q, 2'b00} == `REF_LEVEL_CTRL_ADDR)
        ref_level_q <= hwdata[7:0] & `REF_LEVEL_MASK;
    end
  end

  // read data registered at address phase, zero for unmapped
  always_comb
  begin
    addr_ok = (rd_addr == `GATE_SYNC_CTRL_ADDR) || (rd_addr == `REF_LEVEL_CTRL_ADDR);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (bus_go && !hwrite && addr_ok)
        hrdata <= {24'h000000, (rd_addr == `GATE_SYNC_CTRL_ADDR) ? gate_sync_q
          : ref_level_q};
      else
        hrdata <= '0;
    end
  end

  // comparator latch on falling counter clock edge, or on falling prescaler clock edge when prescaler_enable is set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmp_latched_q <= 1'b0;
    else if (ce && latch_fall)
      cmp_latched_q <= cmp_level;
  end

  // gate routing and counter increment on rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_gate_q <= 1'b0;
      counter_gate_active_q <= 1'b0;
      counter_increment_q <= 1'b0;
    end
    else if (ce)
    begin
      counter_gate_q <= gate_sync_q[`GATE_SEL_BIT] ? gate_level : cmp_path;
      counter_gate_active_q <= counter_on & gate_enable;
      counter_increment_q <= latch_rise & counter_on
        & (~gate_enable | counter_gate_q);
    end
  end

  // reference generator controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reference_power_q <= 1'b0;
      reference_range_low_q <= 1'b0;
      reference_tap_q <= '0;
    end
    else if (ce)
    begin
      reference_power_q <= ref_level_q[`REF_EN_BIT];
      reference_range_low_q <= ref_level_q[`REF_RANGE_BIT];
      reference_tap_q <= ref_level_q[`REF_EN_BIT] ?
        level_type'(ref_level_q[`REF_LEVEL_MSB:0]) : '0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  gate_sel_a: assert property (
    ce && gate_sync_q[`GATE_SEL_BIT] |=> counter_gate_q == $past(gate_level))
    else $error("gate pin not routed");

  comp_route_a: assert property (
    ce && !gate_sync_q[`GATE_SEL_BIT] |=> counter_gate_q == $past(cmp_path))
    else $error("comparator path not routed");

  async_path_a: assert property (
    ce && !gate_sync_q[`SYNC_BIT] && !gate_sync_q[`GATE_SEL_BIT] |=>
      counter_gate_q == $past(cmp_level))
    else $error("comparator not passed through");

  sync_path_a: assert property (
    ce && gate_sync_q[`SYNC_BIT] && !gate_sync_q[`GATE_SEL_BIT] |=>
      counter_gate_q == $past(cmp_latched_q))
    else $error("latched comparator not routed");

  latch_a: assert property (
    ce && latch_fall |=> cmp_latched_q == $past(cmp_level))
    else $error("comparator not latched");

  latch_hold_a: assert property (
    ce && !latch_fall |=> cmp_latched_q == $past(cmp_latched_q))
    else $error("latch changed without falling edge");

  psc_ignore_a: assert property (
    ce && prescaler_enable && !psc_fall |=> cmp_latched_q == $past(cmp_latched_q))
    else $error("latch not on prescaled clock");

  inc_edge_a: assert property (
    $past(ce) && counter_increment_q |-> $past(latch_rise))
    else $error("increment without rising edge");

  inc_free_a: assert property (
    ce && counter_on && !gate_enable && latch_rise |=> counter_increment_q)
    else $error("rising edge missed");

  inc_quiet_a: assert property (
    ce && !latch_rise |=> !counter_increment_q)
    else $error("increment off the rising edge");

  inc_off_a: assert property (
    ce && !counter_on |=> !counter_increment_q)
    else $error("counter advanced while off");

  inc_gate_a: assert property (
    ce && counter_on && gate_enable && !counter_gate_q |=> !counter_increment_q)
    else $error("counter advanced while gated off");

  gate_active_a: assert property (
    ce |=> counter_gate_active_q == $past(counter_on && gate_enable))
    else $error("gate active flag wrong");

  ref_on_a: assert property (
    ce && ref_level_q[`REF_EN_BIT] |=> reference_power_q)
    else $error("reference not powered");

  ref_off_a: assert property (
    ce && !ref_level_q[`REF_EN_BIT] |=> !reference_power_q && reference_tap_q == '0)
    else $error("reference not grounded when off");

  range_a: assert property (
    ce |=> reference_range_low_q == $past(ref_level_q[`REF_RANGE_BIT]))
    else $error("range select wrong");

  tap_a: assert property (
    ce && ref_level_q[`REF_EN_BIT] |=>
      reference_tap_q == $past(ref_level_q[`REF_LEVEL_MSB:0]))
    else $error("reference tap wrong");

  low_range_a: assert property (
    ce && ref_level_q[`REF_EN_BIT] && ref_level_q[`REF_RANGE_BIT] |=>
      reference_range_low_q && reference_power_q)
    else $error("low range not selected");

  high_range_a: assert property (
    ce && ref_level_q[`REF_EN_BIT] && !ref_level_q[`REF_RANGE_BIT] |=>
      !reference_range_low_q && reference_power_q)
    else $error("high range not selected");

  reserved_a: assert property (
    (gate_sync_q & ~`GATE_SYNC_MASK) == '0)
    else $error("reserved gate sync bit set");

  ref_reserved_a: assert property (
    (ref_level_q & ~`REF_LEVEL_MASK) == '0)
    else $error("reserved reference bit set");

  rd_gate_a: assert property (
    ce && bus_go && !hwrite && rd_addr == `GATE_SYNC_CTRL_ADDR |=>
      hrdata == {24'h000000, $past(gate_sync_q)})
    else $error("gate sync read data wrong");

  rd_ref_a: assert property (
    ce && bus_go && !hwrite && rd_addr == `REF_LEVEL_CTRL_ADDR |=>
      hrdata == {24'h000000, $past(ref_level_q)})
    else $error("reference read data wrong");

  gate_write_a: assert property (
    ce && wr_pend_q && {wr_addr_q, 2'b00} == `GATE_SYNC_CTRL_ADDR |=>
      gate_sync_q == ($past(hwdata[7:0]) & `GATE_SYNC_MASK))
    else $error("gate sync write lost");

  resp_okay_a: assert property ( // bus response
    hreadyout && !hresp)
    else $error("bus response not okay");

  freeze_a: assert property ( // clock enable
    !ce |=> gate_sync_q == $past(gate_sync_q) && ref_level_q == $past(ref_level_q))
    else $error("registers changed while frozen");

  sync_cov: cover property (gate_sync_q[`SYNC_BIT] && latch_fall);
  ref_cov: cover property (reference_power_q && reference_range_low_q);
  inc_cov: cover property (counter_increment_q);
  pin_cov: cover property (counter_gate_active_q && counter_gate_q && gate_sync_q[`GATE_SEL_BIT]);
  psc_cov: cover property (prescaler_enable && counter_increment_q);
endmodule

// >>> verilog/cmp_ref_map.svh
`ifndef CMP_REF_MAP_SVH
`define CMP_REF_MAP_SVH
`define GATE_SYNC_CTRL_ADDR 8'h00
`define REF_LEVEL_CTRL_ADDR 8'h04
`define ADDR_MSB 7
`define ADDR_LSB 2
`define GATE_SYNC_RESET 8'h02
`define REF_LEVEL_RESET 8'h00
`define GATE_SYNC_MASK 8'h03
`define REF_LEVEL_MASK 8'haf
`define SYNC_BIT 0
`define GATE_SEL_BIT 1
`define REF_EN_BIT 7
`define REF_RANGE_BIT 5
`define REF_LEVEL_MSB 3
`define HTRANS_NONSEQ_BIT 1
`endif

// >>> verilog/cmp_ref_pkg.sv
package cmp_ref_pkg;
  typedef logic [7:0] reg8_type;
  typedef logic [3:0] level_type;
endpackage

// >>> verilog/edge_sync.sv
module edge_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic async_in,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);
  logic meta_q;
  logic sync_q;

  // two-stage synchroniser plus edge detect on the settled stage only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (ce)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      level_q <= sync_q;
      rise_q <= sync_q & ~level_q;
      fall_q <= ~sync_q & level_q;
    end
  end
endmodule
